// ### adcsr_checker.sv
`timescale 1ns/1ps
// ==============================
// Port checks
module adcsr_checker
(
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire [19:0] conv_word_i,
  input wire conv_valid_i,
  input wire polarity_select_i,
  input wire chip_sel_n_i,
  input wire sclk_i,
  input wire cal_strobe_i,
  input wire serial_data_out_o,
  input wire serial_data_oe_n_o,
  input wire sclk_o,
  input wire sclk_oe_n_o,
  input wire word_ready_n_o,
  input wire cal_busy_o,
  input wire dev_reset_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  // Select falls while no word waits
  sequence s_no_word;
    $fell(chip_sel_n_i) ##0 word_ready_n_o [*4];
  endsequence
  // Serial timing
  a_self_duty: assert property ($rose(sclk_o) |=> !sclk_o [*3])
    else $error("bad self clock duty");
  a_ext_fall: assert property ($changed(serial_data_out_o)
    && !serial_data_oe_n_o && $past(!serial_data_oe_n_o) && sclk_oe_n_o
    |-> !sclk_i) else $error("data moved on rising clock");
  // Select handling
  a_cs_release: assert property ($rose(chip_sel_n_i) && !sclk_oe_n_o
    |-> ##[1:12] serial_data_oe_n_o && sclk_oe_n_o) else $error("no release");
  a_cs_access: assert property ($fell(chip_sel_n_i) && !word_ready_n_o
    |-> ##[1:9] !serial_data_oe_n_o) else $error("data not driven");
  a_cs_refuse: assert property (s_no_word
    |=> serial_data_oe_n_o [*8]) else $error("select taken without word");
  // First bit is the formatted top bit
  a_msb_first: assert property ($fell(serial_data_oe_n_o)
    |-> serial_data_out_o == (conv_word_i[19] ^ polarity_select_i))
    else $error("first bit wrong");
  // Strobe reset and ready guard
  a_cal_reset: assert property (cal_strobe_i [*8] |=> dev_reset_o)
    else $error("no device reset");
  a_ready_guard: assert property (conv_valid_i && serial_data_oe_n_o
    && !cal_busy_o |=> word_ready_n_o ##[2:4] !word_ready_n_o)
    else $error("bad ready guard");
endmodule // adcsr_checker

// ### adcsr_consts.vh
`ifndef ADCSR_CONSTS_VH
`define ADCSR_CONSTS_VH
// Word length and counters
`define ADCSR_WORD_BITS 20
`define ADCSR_BIT_CNT_W 5
`define ADCSR_LAST_BIT 5'h13
// Master clock cycles of the ready-high guard and the calibration strobe
`define ADCSR_GUARD_CYC 3'h4
`define ADCSR_CAL_MIN_CYC 3'h4
// Self-clock divider: quarter rate, high in the phase before a bit change
`define ADCSR_DIV_LAST 2'h3
`define ADCSR_DIV_HIGH 2'h2
// Data access time after chip select, in ns, at a 50 ns clock
`define ADCSR_ACCESS_NS 160
`define ADCSR_CLK_NS 50
// Access delay in whole cycles, rounded up, sized to the access counter
`define ADCSR_ACCESS_CYC 3'h4
// Calibration type codes
`define ADCSR_CAL_SELF 2'h0
`define ADCSR_CAL_SYS_ZERO 2'h1
`define ADCSR_CAL_SYS_FULL 2'h2
`define ADCSR_CAL_SYS_BOTH 2'h3
`endif

// ### adcsr_host.sv
`timescale 1ns/1ps
// ==============================
// Host model
module adcsr_host
(
  input wire clk_sys_i,
  input wire go_i,
  input wire [4:0] nbits_i,
  input wire serial_data_out_i,
  input wire serial_data_out_oe_n_i,
  input wire sclk_i,
  input wire sclk_oe_n_i,
  output reg chip_sel_n_o = 1'b1,
  output reg sclk_o = 1'b0,
  output reg [19:0] word_o = 20'h00000,
  output reg done_o = 1'b0
);
  integer k;
  wire line;
  // Floating line shows the inverse, so stale bits never match
  assign line = serial_data_out_i ^ serial_data_out_oe_n_i;
  // One frame per go; serial clock stands still between frames
  always @(posedge go_i)
  begin
    done_o <= 1'b0;
    word_o <= 20'h00000;
    @(posedge clk_sys_i);
    chip_sel_n_o <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    for (k = 0; k < nbits_i; k = k + 1)
      if (sclk_oe_n_i)
      begin
        sclk_o <= 1'b1;
        @(posedge clk_sys_i);
        word_o <= {word_o[18:0], line};
        repeat (2) @(posedge clk_sys_i);
        sclk_o <= 1'b0; // Long low phase: next bit lands while low
        repeat (5) @(posedge clk_sys_i);
      end
      else
      begin
        @(posedge clk_sys_i);
        while (!sclk_i)
          @(posedge clk_sys_i);
        word_o <= {word_o[18:0], line};
      end
    chip_sel_n_o <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    done_o <= 1'b1;
  end
endmodule // adcsr_host

// ### adcsr_readout.v
`timescale 1ns/1ps
`include "adcsr_consts.vh"
module adcsr_readout
(
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire [19:0] conv_word_i,
  input wire conv_valid_i,
  input wire polarity_select_i,
  input wire mode_strap_i,
  input wire chip_sel_n_i,
  input wire sclk_i,
  input wire cal_strobe_i,
  input wire cal_type_select_a_i,
  input wire cal_type_select_b_i,
  output reg serial_data_out_o,
  output reg serial_data_oe_n_o,
  output reg sclk_o,
  output reg sclk_oe_n_o,
  output reg word_ready_n_o,
  output reg cal_busy_o,
  output reg [1:0] cal_step_o,
  output reg dev_reset_o
);
  // ==========================================================
  // Pin synchronisers
  wire cs_n_s;
  wire sclk_s;
  wire cal_s;
  wire sca_s;
  wire scb_s;
  wire mode_s;
  adcsr_sync2 u_cs (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(chip_sel_n_i), .q_o(cs_n_s));
  adcsr_sync2 u_sck (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(sclk_i), .q_o(sclk_s));
  adcsr_sync2 u_cal (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(cal_strobe_i), .q_o(cal_s));
  adcsr_sync2 u_sca (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(cal_type_select_a_i), .q_o(sca_s));
  adcsr_sync2 u_scb (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(cal_type_select_b_i), .q_o(scb_s));
  adcsr_sync2 u_mod (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(mode_strap_i), .q_o(mode_s));
  wire pol_s;
  adcsr_sync2 u_pol (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .d_i(polarity_select_i), .q_o(pol_s));

  // ==========================================================
  // Edge detection on synchronised pins
  reg cs_n_q;
  reg sclk_q;
  reg cal_q;
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cs_n_q <= 1'b0; // Synchroniser resets low: no false select edge
      sclk_q <= 1'b0;
      cal_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
      cal_q <= cal_s;
    end
  end
  wire cs_fall = cs_n_q & ~cs_n_s;
  wire sclk_fall = sclk_q & ~sclk_s;
  wire cal_rise = cal_s & ~cal_q;
  wire cal_fall = cal_q & ~cal_s;

  // ==========================================================
  // Calibration strobe: length count, select capture, step sequence
  localparam CS_IDLE = 2'h0;
  localparam CS_ZERO = 2'h1;
  localparam CS_FULL = 2'h2;
  localparam CS_SELF = 2'h3;
  reg [2:0] cal_cnt_q;
  reg [1:0] cal_sel_q;
  reg [1:0] cal_st_q;
  reg reset_hit_q;
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cal_cnt_q <= 3'h0;
      cal_sel_q <= `ADCSR_CAL_SELF;
      cal_st_q <= CS_IDLE;
      reset_hit_q <= 1'b0;
      cal_busy_o <= 1'b0;
      cal_step_o <= 2'h0;
      dev_reset_o <= 1'b0;
    end
    else
    begin
      if (cal_rise)
        cal_sel_q <= {scb_s, sca_s};
      if (!cal_s)
        cal_cnt_q <= 3'h0;
      else if (cal_cnt_q != 3'h7)
        cal_cnt_q <= cal_cnt_q + 3'h1;
      // Strictly more than four cycles high means reset
      dev_reset_o <= cal_s && (cal_cnt_q >= `ADCSR_CAL_MIN_CYC);
      if (cal_s && (cal_cnt_q >= `ADCSR_CAL_MIN_CYC))
        reset_hit_q <= 1'b1;
      if (dev_reset_o) // Case below wins on the strobe fall
      begin
        cal_st_q <= CS_IDLE;
        cal_busy_o <= 1'b0;
      end
      case (cal_st_q)
        CS_IDLE:
        begin
          if (cal_fall && reset_hit_q)
          begin
            reset_hit_q <= 1'b0;
            cal_busy_o <= 1'b1;
            if (!cal_sel_q[1])
            begin
              cal_st_q <= CS_ZERO;
              cal_step_o <= `ADCSR_CAL_SYS_ZERO;
            end
            else
            begin
              cal_st_q <= CS_SELF;
              cal_step_o <= `ADCSR_CAL_SELF;
            end
          end
        end
        // Each step ends with the next converted word
        CS_ZERO:
        begin
          if (conv_valid_i)
          begin
            cal_st_q <= CS_FULL;
            cal_step_o <= `ADCSR_CAL_SYS_FULL;
          end
        end
        CS_FULL, CS_SELF:
        begin
          if (conv_valid_i)
          begin
            cal_st_q <= CS_IDLE;
            cal_busy_o <= 1'b0;
            cal_step_o <= 2'h0;
          end
        end
        default: cal_st_q <= CS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Readout engine
  localparam RS_IDLE = 2'h0;
  localparam RS_WAIT = 2'h1;
  localparam RS_SHIFT = 2'h2;
  localparam RS_STOP = 2'h3;
  reg [1:0] rs_q;
  reg [19:0] word_q;
  reg [19:0] shift_q;
  reg [4:0] bit_q;
  reg [2:0] guard_q;
  reg [2:0] acc_q;
  reg [1:0] div_q;
  reg ext_mode_q;
  wire [19:0] coded;
  // Offset binary is the two's complement with MSB flipped
  assign coded = pol_s ?
    {~conv_word_i[19], conv_word_i[18:0]} : conv_word_i;
  // Bit boundary: falling external clock, or end of self-clock period
  wire bit_edge = ext_mode_q ? sclk_fall : (div_q == `ADCSR_DIV_LAST);
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rs_q <= RS_IDLE;
      word_q <= 20'h00000;
      shift_q <= 20'h00000;
      bit_q <= 5'h00;
      guard_q <= 3'h0;
      acc_q <= 3'h0;
      div_q <= 2'h0;
      ext_mode_q <= 1'b1;
      word_ready_n_o <= 1'b1;
      serial_data_out_o <= 1'b0;
      serial_data_oe_n_o <= 1'b1;
      sclk_o <= 1'b0;
      sclk_oe_n_o <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      if (guard_q != 3'h0)
        guard_q <= guard_q - 3'h1;
      // New word replaces an unread one; ready held high four cycles
      if (conv_valid_i && (rs_q == RS_IDLE))
      begin
        word_q <= coded;
        word_ready_n_o <= 1'b1;
        guard_q <= `ADCSR_GUARD_CYC;
      end
      else if (rs_q == RS_IDLE && guard_q == 3'h1)
        word_ready_n_o <= 1'b0;
      case (rs_q)
        RS_IDLE:
        begin
          sclk_oe_n_o <= 1'b1;
          serial_data_oe_n_o <= 1'b1;
          ext_mode_q <= ~mode_s;
          if (cs_fall && !word_ready_n_o && guard_q == 3'h0
              && !conv_valid_i)
          begin
            rs_q <= RS_WAIT;
            shift_q <= word_q;
            acc_q <= 3'h0;
            bit_q <= 5'h00;
          end
        end
        // Data access delay before driving the MSB
        RS_WAIT:
        begin
          acc_q <= acc_q + 3'h1;
          if (acc_q == `ADCSR_ACCESS_CYC)
          begin
            rs_q <= RS_SHIFT;
            serial_data_out_o <= shift_q[19];
            serial_data_oe_n_o <= 1'b0;
            sclk_oe_n_o <= ext_mode_q;
            sclk_o <= 1'b0;
            div_q <= 2'h0;
          end
          else if (cs_n_s)
            rs_q <= RS_IDLE;
        end
        RS_SHIFT:
        begin
          if (!ext_mode_q)
            sclk_o <= (div_q == `ADCSR_DIV_HIGH);
          if (bit_edge)
          begin
            if (bit_q == `ADCSR_LAST_BIT)
            begin
              rs_q <= RS_IDLE;
              word_ready_n_o <= 1'b1;
              serial_data_oe_n_o <= 1'b1;
              sclk_oe_n_o <= 1'b1;
              sclk_o <= 1'b0;
            end
            else if (cs_n_s)
              rs_q <= RS_STOP;
            else
            begin
              bit_q <= bit_q + 5'h01;
              shift_q <= {shift_q[18:0], 1'b0};
              serial_data_out_o <= shift_q[18];
            end
          end
        end
        // Abandoned word: float pins, word stays for a later read
        RS_STOP:
        begin
          serial_data_oe_n_o <= 1'b1;
          sclk_oe_n_o <= 1'b1;
          sclk_o <= 1'b0;
          rs_q <= RS_IDLE;
        end
        default: rs_q <= RS_IDLE;
      endcase
      if (dev_reset_o)
      begin
        rs_q <= RS_IDLE;
        word_ready_n_o <= 1'b1;
        serial_data_oe_n_o <= 1'b1;
        sclk_oe_n_o <= 1'b1;
      end
    end
  end
endmodule // adcsr_readout

// ### adcsr_sync2.v
`timescale 1ns/1ps
`include "adcsr_consts.vh"
// Two-flop synchroniser for pins from outside the clock domain
module adcsr_sync2
(
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire d_i,
  output wire q_o
);
  reg s1_q;
  reg s2_q;
  // First flop feeds only the second
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule // adcsr_sync2

// ### adcsr_tb.sv
`timescale 1ns/1ps
// ==============================
// Bench top
module testbench;
  reg clk_sys_i = 1'b0, arst_n_i = 1'b0, conv_valid_i = 1'b0, go = 1'b0;
  reg polarity_select_i = 1'b0, mode_strap_i = 1'b0, cal_strobe_i = 1'b0;
  reg cal_type_select_a_i = 1'b0, cal_type_select_b_i = 1'b0;
  reg [19:0] conv_word_i = 20'h00000, w;
  reg [4:0] nbits = 5'h00;
  wire chip_sel_n_i, sclk_i, serial_data_out_o, serial_data_oe_n_o, done;
  wire sclk_o, sclk_oe_n_o, word_ready_n_o, cal_busy_o, dev_reset_o;
  wire [1:0] cal_step_o;
  wire [19:0] got;
  integer n_mismatch = 0, check_count = 0, i;
  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;
  adcsr_readout u_dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .conv_word_i(conv_word_i),
    .conv_valid_i(conv_valid_i),
    .polarity_select_i(polarity_select_i),
    .mode_strap_i(mode_strap_i),
    .chip_sel_n_i(chip_sel_n_i),
    .sclk_i(sclk_i),
    .cal_strobe_i(cal_strobe_i),
    .cal_type_select_a_i(cal_type_select_a_i),
    .cal_type_select_b_i(cal_type_select_b_i),
    .serial_data_out_o(serial_data_out_o),
    .serial_data_oe_n_o(serial_data_oe_n_o),
    .sclk_o(sclk_o),
    .sclk_oe_n_o(sclk_oe_n_o),
    .word_ready_n_o(word_ready_n_o),
    .cal_busy_o(cal_busy_o),
    .cal_step_o(cal_step_o),
    .dev_reset_o(dev_reset_o)
  );
  adcsr_host u_host (.clk_sys_i(clk_sys_i), .go_i(go), .nbits_i(nbits),
    .serial_data_out_i(serial_data_out_o), .serial_data_out_oe_n_i(serial_data_oe_n_o),
    .sclk_i(sclk_o), .sclk_oe_n_i(sclk_oe_n_o), .chip_sel_n_o(chip_sel_n_i),
    .sclk_o(sclk_i), .word_o(got), .done_o(done));
  // Compare and count
  task check(input string what, input [19:0] seen, input [19:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // New word from the core, then past the ready guard
  task load(input [19:0] raw);
  begin
    conv_word_i <= raw;
    conv_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    conv_valid_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  end
  endtask
  // One host frame of n bits
  task frame(input [4:0] n);
  begin
    nbits <= n;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    @(posedge done);
    @(posedge clk_sys_i);
  end
  endtask
  task test_done;
  begin
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Watchdog, well past the expected run
  initial
  begin
    #500000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check("idle", {word_ready_n_o, serial_data_oe_n_o, cal_busy_o}, 20'h6);
    frame(5'h00);
    // Both polarities in both readout modes
    for (i = 0; i < 4; i = i + 1)
    begin
      polarity_select_i <= i[0];
      mode_strap_i <= i[1];
      // Polarity pin is synchronised: let it settle before the word
      repeat (2) @(posedge clk_sys_i);
      w = i[1] ? 20'h00001 : 20'hFFFFE;
      load(w);
      check("ready_n", word_ready_n_o, 20'h0);
      frame(5'h14);
      check("word", got, w ^ {i[0], 19'h00000});
      check("end", {word_ready_n_o, serial_data_oe_n_o}, 20'h3);
    end
    load(20'h5A5A5);
    frame(5'h05);
    check("abort", {serial_data_oe_n_o, sclk_oe_n_o, word_ready_n_o}, 20'h6);
    frame(5'h14);
    check("reread", got, 20'hDA5A5);
    mode_strap_i <= 1'b0;
    load(20'h12345);
    load(20'h0ABCD);
    frame(5'h14);
    check("newer", got, 20'h8ABCD);
    // System then self calibration
    for (i = 0; i < 2; i = i + 1)
    begin
      cal_type_select_a_i <= i[0];
      cal_type_select_b_i <= i[0];
      @(posedge clk_sys_i);
      cal_strobe_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      check("dev_reset", dev_reset_o, 20'h1);
      cal_strobe_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      check("cal", {cal_busy_o, cal_step_o}, i[0] ? 20'h4 : 20'h5);
      load(20'h00000);
      if (i == 0)
        check("cal", {cal_busy_o, cal_step_o}, 20'h6);
      load(20'h00000);
      check("cal_end", {cal_busy_o, cal_step_o}, 20'h0);
    end
    test_done;
  end
endmodule // testbench
bind adcsr_readout adcsr_checker u_chk (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .conv_word_i(conv_word_i),
  .conv_valid_i(conv_valid_i),
  .polarity_select_i(polarity_select_i),
  .chip_sel_n_i(chip_sel_n_i),
  .sclk_i(sclk_i),
  .cal_strobe_i(cal_strobe_i),
  .serial_data_out_o(serial_data_out_o),
  .serial_data_oe_n_o(serial_data_oe_n_o),
  .sclk_o(sclk_o),
  .sclk_oe_n_o(sclk_oe_n_o),
  .word_ready_n_o(word_ready_n_o),
  .cal_busy_o(cal_busy_o),
  .dev_reset_o(dev_reset_o)
);
